// ===== core/pse_event_summary_mask.sv
// event summary register, mask register and event pin driver
`timescale 1ns/1ps
`default_nettype none
`include "pse_event_map.svh"
module pse_event_summary_mask
  import pse_event_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic thermal_shutdown_flag,
  input wire logic logic_supply_undervolt_flag,
  input wire logic power_supply_undervolt_flag,
  input wire logic supply_event_clear,
  input wire logic clear_all_events,
  input wire port_flags_t port_startup_timeout_flag,
  input wire port_flags_t port_overload_cutoff_flag,
  input wire port_flags_t port_current_limit_flag,
  input wire port_flags_t port_class_cycle_flag,
  input wire port_flags_t port_detect_cycle_flag,
  input wire port_flags_t port_disconnect_flag,
  input wire port_flags_t port_power_good_change_flag,
  input wire port_flags_t port_power_enable_change_flag,
  input wire logic event_output_global_enable,
  input wire logic cmd_read,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_wdata,
  output logic [7:0] cmd_rdata_q,
  output logic cmd_rvalid_q,
  output logic event_n_q
);
  event_byte_t summary_q;
  event_byte_t summary_d;
  event_byte_t event_mask_q;
  logic supply_any;
  event_gate_if gif ();

  // every check in this module runs on core_clk and sleeps through reset
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  assign supply_any = thermal_shutdown_flag | logic_supply_undervolt_flag
                    | power_supply_undervolt_flag;

  // per-port flags are sticky upstream and cleared there by the
  // clear-on-read accesses, so the port bits simply follow their OR;
  // the supply bit has to hold on its own to honour its reset value of 1
  always_comb begin
    summary_d = summary_q;
    // set beats the clear when a new supply fault lands on it
    if (supply_any) begin
      summary_d[`BIT_SUPPLY] = 1'b1;
    end else if (supply_event_clear || clear_all_events) begin
      summary_d[`BIT_SUPPLY] = 1'b0;
    end
    summary_d[`BIT_STARTUP] = |port_startup_timeout_flag;
    summary_d[`BIT_OVERCURRENT] = |port_overload_cutoff_flag
                                | |port_current_limit_flag;
    summary_d[`BIT_CLASS] = |port_class_cycle_flag;
    summary_d[`BIT_DETECT] = |port_detect_cycle_flag;
    summary_d[`BIT_DISCONNECT] = |port_disconnect_flag;
    summary_d[`BIT_POWER_GOOD] = |port_power_good_change_flag;
    summary_d[`BIT_POWER_ENABLE] = |port_power_enable_change_flag;
  end

  // the summary never looks at the mask
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      summary_q <= `SUMMARY_RESET;
    end else begin
      summary_q <= summary_d;
    end
  end

  // a read in the same cycle as a write still sees the old mask
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      event_mask_q <= `MASK_RESET;
    end else if (cmd_write && cmd_code == `CMD_EVENT_MASK) begin
      event_mask_q <= cmd_wdata;
    end
  end

  // writes to the summary code fall on nothing: it is read-only
  // rvalid follows every read, mapped or not, so the host never waits
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_rdata_q <= `READ_UNMAPPED;
      cmd_rvalid_q <= 1'b0;
    end else begin
      cmd_rvalid_q <= cmd_read;
      if (cmd_read) begin
        unique case (cmd_code)
          `CMD_EVENT_SUMMARY: cmd_rdata_q <= summary_q;
          `CMD_EVENT_MASK: cmd_rdata_q <= event_mask_q;
          default: cmd_rdata_q <= `READ_UNMAPPED;
        endcase
      end
    end
  end

  assign gif.summary = summary_q;
  assign gif.mask = event_mask_q;
  assign gif.global_en = event_output_global_enable;

  // the gate is pure logic; the flop below is the only pin driver
  event_pin_gate #(.WIDTH(8)) u_gate (
    .gif(gif)
  );

  // registered so the pin never glitches while the OR tree settles;
  // the cost is one extra cycle of latency on assert and release
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      event_n_q <= 1'b1;
    end else begin
      event_n_q <= ~gif.request;
    end
  end

  // a clear only bites when no supply fault lands in the same cycle
  sequence supply_clear_s;
    !supply_any && (supply_event_clear || clear_all_events);
  endsequence
  sequence disconnect_seen_s;
    |port_disconnect_flag;
  endsequence
  sequence disconnect_let_through_s;
    event_mask_q[`BIT_DISCONNECT] && event_output_global_enable;
  endsequence
  sequence port_flag_seen_s;
    |port_startup_timeout_flag;
  endsequence
  sequence startup_bit_up_s;
    ##1 summary_q[`BIT_STARTUP];
  endsequence

  supply_sticky_a: assert property (
    supply_any |=> summary_q[`BIT_SUPPLY])
    else $error("supply summary bit missed a supply fault");
  supply_hold_a: assert property (
    summary_q[`BIT_SUPPLY] && !supply_event_clear && !clear_all_events
    |=> summary_q[`BIT_SUPPLY])
    else $error("supply summary bit dropped without a clear");
  startup_or_a: assert property (
    port_flag_seen_s |-> startup_bit_up_s)
    else $error("start-up summary bit missed a port flag");
  current_or_a: assert property (
    summary_q[`BIT_OVERCURRENT] ==
    $past(|port_overload_cutoff_flag | |port_current_limit_flag))
    else $error("overcurrent summary bit wrong");
  class_detect_or_a: assert property (
    {summary_q[`BIT_CLASS], summary_q[`BIT_DETECT]} ==
    $past({|port_class_cycle_flag, |port_detect_cycle_flag}))
    else $error("class or detect summary bit wrong");
  low_bits_or_a: assert property (
    summary_q[2:0] == $past({|port_disconnect_flag,
      |port_power_good_change_flag, |port_power_enable_change_flag}))
    else $error("low summary bits wrong");
  mask_write_a: assert property (
    cmd_write && cmd_code == `CMD_EVENT_MASK
    |=> cmd_read && cmd_code == `CMD_EVENT_MASK
    |=> cmd_rvalid_q && cmd_rdata_q == $past(cmd_wdata, 2))
    else $error("mask read back differs from write");
  summary_read_a: assert property (
    cmd_read && cmd_code == `CMD_EVENT_SUMMARY
    |=> cmd_rvalid_q && cmd_rdata_q == $past(summary_q))
    else $error("summary read returned wrong byte");
  pin_gate_a: assert property (
    !event_n_q == $past(event_output_global_enable &&
      |(summary_q & event_mask_q)))
    else $error("event pin disagrees with masked summary");
  pin_release_a: assert property (
    !event_n_q && summary_d == 8'h00 |-> ##2 event_n_q)
    else $error("event pin not released after clear");
  // the checks below cover the clears, the mask hold, the read path and the pin gate
  supply_clear_a: assert property (
    supply_clear_s |=> !summary_q[`BIT_SUPPLY])
    else $error("supply summary bit survived a clear");
  startup_clear_a: assert property (
    !(|port_startup_timeout_flag) |=> !summary_q[`BIT_STARTUP])
    else $error("start-up summary bit set with no port flag");
  mask_hold_a: assert property (
    !(cmd_write && cmd_code == `CMD_EVENT_MASK) |=> $stable(event_mask_q))
    else $error("mask changed without a mask write");
  rvalid_only_a: assert property (
    !cmd_read |=> !cmd_rvalid_q)
    else $error("read valid without a read");
  unmapped_read_a: assert property (
    cmd_read && cmd_code != `CMD_EVENT_SUMMARY
    && cmd_code != `CMD_EVENT_MASK |=> cmd_rdata_q == `READ_UNMAPPED)
    else $error("unmapped read returned data");
  // pin stays high whenever no unmasked event is pending
  mask_gate_a: assert property (
    (summary_q & event_mask_q) == 8'h00 |=> event_n_q)
    else $error("event pin low with every event masked");
  pin_disable_a: assert property (
    !event_output_global_enable |=> event_n_q)
    else $error("event pin low with global enable off");
  disconnect_pin_a: assert property (
    disconnect_seen_s ##1 disconnect_let_through_s |=> !event_n_q)
    else $error("unmasked disconnect did not reach the event pin");
endmodule
`default_nettype wire

// ===== core/pse_event_map.svh
// register map and field layout of the event summary and mask block
`ifndef PSE_EVENT_MAP_SVH
`define PSE_EVENT_MAP_SVH

`define CMD_EVENT_SUMMARY 8'h00
`define CMD_EVENT_MASK 8'h01

`define SUMMARY_RESET 8'h80
`define MASK_RESET 8'h80
`define READ_UNMAPPED 8'h00

`define BIT_SUPPLY 7
`define BIT_STARTUP 6
`define BIT_OVERCURRENT 5
`define BIT_CLASS 4
`define BIT_DETECT 3
`define BIT_DISCONNECT 2
`define BIT_POWER_GOOD 1
`define BIT_POWER_ENABLE 0

`endif

// ===== core/pse_event_pkg.sv
// types shared by the event summary and mask block
package pse_event_pkg;
  typedef logic [7:0] event_byte_t;
  typedef logic [3:0] port_flags_t;
endpackage

// ===== core/event_gate_if.sv
// carrier between the summary register and the event pin gate
`timescale 1ns/1ps
`default_nettype none
interface event_gate_if;
  logic [7:0] summary;
  logic [7:0] mask;
  logic global_en;
  logic request;
  modport gate (input summary, input mask, input global_en, output request);
  modport owner (output summary, output mask, output global_en, input request);
endinterface
`default_nettype wire

// ===== core/event_pin_gate.sv
// masked and globally enabled OR of the summary bits
`timescale 1ns/1ps
`default_nettype none
module event_pin_gate #(
  parameter int WIDTH = 8
) (
  event_gate_if.gate gif
);
  logic [WIDTH-1:0] masked;

  // a zero mask bit keeps its event off the pin
  assign masked = gif.summary[WIDTH-1:0] & gif.mask[WIDTH-1:0];
  // pin request needs the global enable as well
  assign gif.request = (|masked) & gif.global_en;
endmodule
`default_nettype wire

// ===== sim/event_host_model.sv
// host command driver standing in for the serial bus engine
`timescale 1ns/1ps
`default_nettype none
module event_host_model (
  input wire logic core_clk,
  input wire logic cmd_rvalid_q,
  input wire logic [7:0] cmd_rdata_q,
  output logic cmd_read,
  output logic cmd_write,
  output logic [7:0] cmd_code,
  output logic [7:0] cmd_wdata
);
  initial {cmd_read, cmd_write, cmd_code, cmd_wdata} = 18'h0_0000;
  // idle data goes to its inverse so a stale byte cannot pass
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    @(posedge core_clk) #1;
    cmd_write = 1'b1;
    cmd_code = c;
    cmd_wdata = d;
    @(posedge core_clk) #1;
    cmd_write = 1'b0;
    cmd_wdata = ~d;
  endtask
  // answer is fixed at one edge after the read edge
  task automatic rd(input logic [7:0] c, output logic [7:0] d,
                    output logic ok);
    @(posedge core_clk) #1;
    cmd_read = 1'b1;
    cmd_code = c;
    @(posedge core_clk) #1;
    cmd_read = 1'b0;
    d = cmd_rdata_q;
    ok = cmd_rvalid_q;
  endtask
  // write then read back at the very next edge, as the port allows
  task automatic wr_rd(input logic [7:0] c, input logic [7:0] d,
                       output logic [7:0] q, output logic ok);
    @(posedge core_clk) #1;
    cmd_write = 1'b1;
    cmd_code = c;
    cmd_wdata = d;
    @(posedge core_clk) #1;
    cmd_write = 1'b0;
    cmd_wdata = ~d;
    cmd_read = 1'b1;
    @(posedge core_clk) #1;
    cmd_read = 1'b0;
    q = cmd_rdata_q;
    ok = cmd_rvalid_q;
  endtask
endmodule
`default_nettype wire

// ===== sim/pse_event_summary_mask_bench.sv
// self-checking bench for the event summary and mask block
`timescale 1ns/1ps
`default_nettype none
module pse_event_summary_mask_bench;
  import pse_event_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic en = 1'b0;
  logic sclr = 1'b0;
  logic aclr = 1'b0;
  logic [2:0] sup = 3'h0;
  port_flags_t fl [8] = '{default: 4'h0};
  logic rd_ok;
  event_byte_t got;
  wire logic cmd_read, cmd_write, cmd_rvalid_q, event_n_q;
  wire logic [7:0] cmd_code, cmd_wdata, cmd_rdata_q;
  int bad_count = 0;
  int n_checks = 0;
  int k;
  event_byte_t bit_k;
  always #4 core_clk = ~core_clk;
  event_host_model i_event_host_model (.core_clk(core_clk),
    .cmd_rvalid_q(cmd_rvalid_q), .cmd_rdata_q(cmd_rdata_q),
    .cmd_read(cmd_read), .cmd_write(cmd_write), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata));
  pse_event_summary_mask i_pse_event_summary_mask (.core_clk(core_clk),
    .rst_b(rst_b), .thermal_shutdown_flag(sup[0]),
    .logic_supply_undervolt_flag(sup[1]),
    .power_supply_undervolt_flag(sup[2]), .supply_event_clear(sclr),
    .clear_all_events(aclr), .port_startup_timeout_flag(fl[6]),
    .port_overload_cutoff_flag(fl[5]), .port_current_limit_flag(fl[7]),
    .port_class_cycle_flag(fl[4]), .port_detect_cycle_flag(fl[3]),
    .port_disconnect_flag(fl[2]), .port_power_good_change_flag(fl[1]),
    .port_power_enable_change_flag(fl[0]),
    .event_output_global_enable(en), .cmd_read(cmd_read),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .cmd_rdata_q(cmd_rdata_q), .cmd_rvalid_q(cmd_rvalid_q),
    .event_n_q(event_n_q));
  task automatic chk8(input event_byte_t g, input event_byte_t e);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t byte %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t bit %b expected %b", $time, g, e);
    end
  endtask
  task automatic rdchk(input logic [7:0] c, input event_byte_t e);
    i_event_host_model.rd(c, got, rd_ok);
    chk1(rd_ok, 1'b1);
    chk8(got, e);
  endtask
  task automatic wrchk(input logic [7:0] c, input event_byte_t e);
    i_event_host_model.wr_rd(c, e, got, rd_ok);
    chk1(rd_ok, 1'b1);
    chk8(got, e);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    tick(8);
    rst_b = 1'b1;
    chk1(event_n_q, 1'b1);
    rdchk(8'h00, 8'h80);
    rdchk(8'h01, 8'h80);
    rdchk(8'h07, 8'h00);
    i_event_host_model.wr(8'h00, 8'h00);
    rdchk(8'h00, 8'h80);
    en = 1'b1;
    tick(2);
    chk1(event_n_q, 1'b0);
    sclr = 1'b1;
    tick(1);
    sclr = 1'b0;
    tick(2);
    chk1(event_n_q, 1'b1);
    rdchk(8'h00, 8'h00);
    $display("test reset and supply clear done");
    for (int i = 0; i < 3; i++) begin
      sup[i] = 1'b1;
      tick(1);
      sup[i] = 1'b0;
      tick(2);
      chk1(event_n_q, 1'b0);
      aclr = 1'b1;
      tick(1);
      aclr = 1'b0;
      tick(2);
      chk1(event_n_q, 1'b1);
    end
    sup[0] = 1'b1;
    aclr = 1'b1;
    tick(1);
    sup[0] = 1'b0;
    aclr = 1'b0;
    tick(2);
    chk1(event_n_q, 1'b0);
    rdchk(8'h00, 8'h80);
    sclr = 1'b1;
    tick(1);
    sclr = 1'b0;
    rdchk(8'h00, 8'h00);
    $display("test supply faults done");
    // index 7 is the current-limit set, which shares summary bit 5
    for (int b = 0; b < 8; b++) begin
      k = (b == 7) ? 5 : b;
      bit_k = 8'h01 << k;
      i_event_host_model.wr(8'h01, ~bit_k);
      fl[b][b % 4] = 1'b1;
      tick(3);
      chk1(event_n_q, 1'b1);
      rdchk(8'h00, bit_k);
      wrchk(8'h01, bit_k);
      chk1(event_n_q, 1'b0);
      en = 1'b0;
      tick(2);
      chk1(event_n_q, 1'b1);
      en = 1'b1;
      fl[b] = 4'h0;
      tick(3);
      chk1(event_n_q, 1'b1);
      rdchk(8'h00, 8'h00);
    end
    $display("test port events done");
    test_done();
  end
  initial begin
    #50000;
    bad_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    test_done();
  end
endmodule
`default_nettype wire
